// ---- hw/ldsc_divider.sv ----
// programmable divider fed by pre-divider ticks, with stop/arm/run control
module ldsc_divider
    import ldsc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_tick,
    input wire logic [7:0] i_code,
    input wire logic i_soft_reset,
    output logic o_div_clk,
    output ldsc_div_state_type o_state,
    output logic [8:0] o_ratio
);
    ldsc_div_state_type state_r, state_nxt;
    logic [8:0] cnt_r, cnt_nxt;
    logic out_r, out_nxt;
    logic [8:0] ratio;

    // codes zero to five share the floor ratio, codes from six divide by code plus one
    always_comb begin
        if (i_code <= DIV_CODE_LOW_MAX) begin // see (RULE4)
            ratio = DIV_RATIO_FLOOR;
        end else begin
            ratio = {1'b0, i_code} + 9'h001; // see (RULE5)
        end
    end

    // next state, count and output level
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        out_nxt = out_r;
        case (state_r)
            DIV_STOP: begin
                if (i_code != DIV_CODE_OFF) begin
                    state_nxt = DIV_ARMED;
                end
            end
            DIV_ARMED: begin
                // a fresh code waits for the channel soft reset to start clean
                if (i_code == DIV_CODE_OFF) begin
                    state_nxt = DIV_STOP;
                end else if (i_soft_reset) begin // see (RULE3) see (RULE8)
                    state_nxt = DIV_RUN;
                    cnt_nxt = 9'h000;
                    out_nxt = 1'b1;
                end
            end
            DIV_RUN: begin
                if (i_code == DIV_CODE_OFF) begin // see (RULE3)
                    state_nxt = DIV_STOP;
                    cnt_nxt = 9'h000;
                    out_nxt = 1'b0;
                end else if (i_soft_reset) begin // see (RULE8)
                    cnt_nxt = 9'h000;
                    out_nxt = 1'b1;
                end else if (i_tick) begin // see (RULE2)
                    // wrap also covers a ratio shrunk below the current count
                    cnt_nxt = (cnt_r >= ratio - 9'h001) ? 9'h000 : cnt_r + 9'h001; // see (RULE1)
                    out_nxt = (cnt_nxt < (ratio >> 1));
                end
            end
            default: begin
                state_nxt = DIV_STOP;
                cnt_nxt = 9'h000;
                out_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_r <= DIV_STOP;
            cnt_r <= 9'h000;
            out_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            out_r <= out_nxt;
        end
    end

    assign o_div_clk = out_r;
    assign o_state = state_r;
    assign o_ratio = ratio;

    property p_count_on_tick_only;
        @(posedge i_clk) disable iff (i_rst)
        (state_r == DIV_RUN && !i_tick && !i_soft_reset && i_code != DIV_CODE_OFF)
            |=> (cnt_r == $past(cnt_r));
    endproperty
    a_count_on_tick_only: assert property (p_count_on_tick_only) // see (RULE2)
        else $error("divider count moved without a source tick");

    property p_low_codes_six;
        @(posedge i_clk) disable iff (i_rst)
        (i_code != DIV_CODE_OFF && i_code <= DIV_CODE_LOW_MAX) |-> (o_ratio == 9'h006);
    endproperty
    a_low_codes_six: assert property (p_low_codes_six) // see (RULE4)
        else $error("codes one to five must divide by six");

    property p_high_codes_plus_one;
        @(posedge i_clk) disable iff (i_rst)
        (i_code > DIV_CODE_LOW_MAX) |-> (o_ratio == {1'b0, i_code} + 9'h001);
    endproperty
    a_high_codes_plus_one: assert property (p_high_codes_plus_one) // see (RULE5)
        else $error("codes from six must divide by code plus one");
endmodule : ldsc_divider

// ---- hw/ldsc_edge_rate.sv ----
// per-pin edge-rate decode of the stored slew fields
module ldsc_edge_rate
    import ldsc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [3:0] i_fields,
    output logic [1:0] o_slow
);
    logic [1:0] slow_r, slow_nxt;

    // only code two means slow; reserved codes fall back to fast
    genvar g;
    generate
        for (g = 0; g < PIN_COUNT; g++) begin : g_pin
            assign slow_nxt[g] = (i_fields[g*EDGE_FIELD_W +: EDGE_FIELD_W] == EDGE_SLOW);
        end
    endgenerate

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            slow_r <= 2'b00;
        end else begin
            slow_r <= slow_nxt;
        end
    end

    assign o_slow = slow_r;
endmodule : ldsc_edge_rate

// ---- hw/ldsc_pkg.sv ----
// shared constants and types of the lvcmos divider and edge-rate block
package ldsc_pkg;
    // register indices and their byte addresses (four bytes per index)
    localparam logic [7:0] DIV_B_RATIO_IDX = 8'h2f;
    localparam logic [7:0] EDGE_RATE_IDX = 8'h31;
    localparam logic [7:0] CHAN_CTRL_IDX = 8'h32;
    localparam logic [7:0] CHAN_STAT_IDX = 8'h33;
    localparam logic [9:0] DIV_B_RATIO_ADDR = {DIV_B_RATIO_IDX, 2'b00};
    localparam logic [9:0] EDGE_RATE_ADDR = {EDGE_RATE_IDX, 2'b00};
    localparam logic [9:0] CHAN_CTRL_ADDR = {CHAN_CTRL_IDX, 2'b00};
    localparam logic [9:0] CHAN_STAT_ADDR = {CHAN_STAT_IDX, 2'b00};
    // reset values
    localparam logic [7:0] DIV_B_RESET = 8'h00;
    localparam logic [3:0] EDGE_RATE_RESET = 4'h0;
    // field positions
    localparam int DIV_CODE_W = 8;
    localparam int RATIO_W = 9;
    localparam int EDGE_FIELD_W = 2;
    localparam int EDGE_STORED_W = 4;
    localparam int SOFT_RESET_BIT = 0;
    localparam int PIN_COUNT = 2;
    // divider code map
    localparam logic [7:0] DIV_CODE_OFF = 8'h00;
    localparam logic [7:0] DIV_CODE_LOW_MAX = 8'h05;
    localparam logic [8:0] DIV_RATIO_FLOOR = 9'h006;
    // edge-rate encodings
    localparam logic [1:0] EDGE_FAST = 2'h0;
    localparam logic [1:0] EDGE_SLOW = 2'h2;
    // ahb-lite constants
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;
    // divider channel states, gray coded along stop -> armed -> run
    typedef enum logic [1:0] {
        DIV_STOP = 2'b00,
        DIV_ARMED = 2'b01,
        DIV_RUN = 2'b11
    } ldsc_div_state_type;
endpackage : ldsc_pkg

// ---- hw/ldsc_top.sv ----
// ahb-lite register slave with lvcmos divider b and indicator edge-rate control
//
// Overview of operation
// (RULE1) eight-bit code sets divider b ratio
// (RULE2) divider counts second pll pre-divider ticks
// (RULE3) code zero stops; restart needs soft reset
// (RULE4) codes one to five divide by six
// (RULE5) codes six up divide by code+1
// (RULE6) bits 3:2 set pin one edge rate
// (RULE7) bits 1:0 set pin zero edge rate
// (RULE8) writing one starts channel soft reset
// (RULE9) upper slew bits ignore writes, read zero
module ldsc_top
    import ldsc_pkg::*;
(
    input wire logic I_MCLK,
    input wire logic I_RST,
    input wire logic I_HSEL,
    input wire logic [31:0] I_HADDR,
    input wire logic [1:0] I_HTRANS,
    input wire logic I_HWRITE,
    input wire logic [2:0] I_HSIZE,
    input wire logic [31:0] I_HWDATA,
    input wire logic I_HREADY,
    output logic [31:0] O_HRDATA,
    output logic O_HREADYOUT,
    output logic O_HRESP,
    input wire logic I_PREDIV_TICK,
    output logic O_LVCMOS_B_CLK,
    output logic O_IND0_SLOW,
    output logic O_IND1_SLOW
);
    // address-phase capture
    logic dp_valid_r, dp_valid_nxt;
    logic dp_write_r, dp_write_nxt;
    logic [9:0] dp_addr_r, dp_addr_nxt;
    // registers
    logic [7:0] div_code_r, div_code_nxt;
    logic [3:0] edge_r, edge_nxt;
    logic swr_r, swr_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    // decode helpers
    logic addr_phase;
    logic wr_en;
    logic [1:0] slow;
    ldsc_div_state_type div_state;
    logic [8:0] div_ratio;
    logic div_clk;

    // a transfer is taken when selected, the bus is ready and htrans is active
    assign addr_phase = I_HSEL && I_HREADY && I_HTRANS[1];
    assign wr_en = dp_valid_r && dp_write_r;

    // address-phase bookkeeping; only the low ten address bits are decoded
    always_comb begin
        dp_valid_nxt = addr_phase;
        dp_write_nxt = addr_phase ? I_HWRITE : 1'b0;
        dp_addr_nxt = addr_phase ? I_HADDR[9:0] : dp_addr_r;
    end

    // register writes land in the data phase, when hwdata is valid
    always_comb begin
        div_code_nxt = div_code_r;
        edge_nxt = edge_r;
        swr_nxt = 1'b0;
        if (wr_en) begin
            case (dp_addr_r)
                DIV_B_RATIO_ADDR: begin
                    div_code_nxt = I_HWDATA[7:0]; // see (RULE1)
                end
                EDGE_RATE_ADDR: begin
                    // upper four bits are not stored at all
                    edge_nxt = I_HWDATA[3:0]; // see (RULE6) see (RULE7) see (RULE9)
                end
                CHAN_CTRL_ADDR: begin
                    swr_nxt = I_HWDATA[SOFT_RESET_BIT]; // see (RULE8)
                end
                default: begin
                    div_code_nxt = div_code_r;
                end
            endcase
        end
    end

    // read data is prepared in the address phase so it stands from a flop
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (addr_phase && !I_HWRITE) begin
            case (I_HADDR[9:0])
                DIV_B_RATIO_ADDR: begin
                    rdata_nxt = {24'h00_0000, div_code_r};
                end
                EDGE_RATE_ADDR: begin
                    rdata_nxt = {28'h000_0000, edge_r}; // see (RULE9)
                end
                CHAN_STAT_ADDR: begin
                    rdata_nxt = {29'h0000_0000, div_clk, div_state};
                end
                default: begin
                    rdata_nxt = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            dp_valid_r <= 1'b0;
            dp_write_r <= 1'b0;
            dp_addr_r <= 10'h000;
            div_code_r <= DIV_B_RESET;
            edge_r <= EDGE_RATE_RESET;
            swr_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end else begin
            dp_valid_r <= dp_valid_nxt;
            dp_write_r <= dp_write_nxt;
            dp_addr_r <= dp_addr_nxt;
            div_code_r <= div_code_nxt;
            edge_r <= edge_nxt;
            swr_r <= swr_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // zero wait states; every answer is okay, unmapped reads give zero
    assign O_HREADYOUT = 1'b1;
    assign O_HRESP = HRESP_OKAY;
    assign O_HRDATA = rdata_r;

    ldsc_divider u_divider (
        .i_clk(I_MCLK),
        .i_rst(I_RST),
        .i_tick(I_PREDIV_TICK),
        .i_code(div_code_r),
        .i_soft_reset(swr_r),
        .o_div_clk(div_clk),
        .o_state(div_state),
        .o_ratio(div_ratio)
    );

    ldsc_edge_rate u_edge_rate (
        .i_clk(I_MCLK),
        .i_rst(I_RST),
        .i_fields(edge_r),
        .o_slow(slow)
    );

    assign O_LVCMOS_B_CLK = div_clk;
    assign O_IND0_SLOW = slow[0];
    assign O_IND1_SLOW = slow[1];

    // checks ---------------------------------------------------------------
    sequence s_div_write;
        wr_en && dp_addr_r == DIV_B_RATIO_ADDR;
    endsequence

    sequence s_swr_request;
        wr_en && dp_addr_r == CHAN_CTRL_ADDR && I_HWDATA[SOFT_RESET_BIT];
    endsequence

    property p_code_loads;
        @(posedge I_MCLK) disable iff (I_RST)
        s_div_write |=> (div_code_r == $past(I_HWDATA[7:0]));
    endproperty
    a_code_loads: assert property (p_code_loads) // see (RULE1)
        else $error("divider code did not take the written value");

    property p_zero_stops;
        @(posedge I_MCLK) disable iff (I_RST)
        (div_code_r == DIV_CODE_OFF) |=> (div_state == DIV_STOP) ##1 !div_clk;
    endproperty
    a_zero_stops: assert property (p_zero_stops) // see (RULE3)
        else $error("code zero did not stop the divider");

    property p_armed_waits;
        @(posedge I_MCLK) disable iff (I_RST)
        (div_state == DIV_ARMED && !swr_r) |=> (div_state != DIV_RUN);
    endproperty
    a_armed_waits: assert property (p_armed_waits) // see (RULE3)
        else $error("divider restarted without a soft reset");

    property p_swr_starts;
        @(posedge I_MCLK) disable iff (I_RST)
        (s_swr_request ##1 (div_code_r != DIV_CODE_OFF)) |=> (div_state == DIV_RUN && div_clk);
    endproperty
    a_swr_starts: assert property (p_swr_starts) // see (RULE8)
        else $error("soft reset did not start the divider");

    property p_pin_one_slew;
        @(posedge I_MCLK) disable iff (I_RST)
        (edge_r[3:2] == EDGE_SLOW) |=> O_IND1_SLOW;
    endproperty
    a_pin_one_slew: assert property (p_pin_one_slew) // see (RULE6)
        else $error("pin one edge rate not slow for code two");

    property p_pin_zero_slew;
        @(posedge I_MCLK) disable iff (I_RST)
        (edge_r[1:0] == EDGE_FAST) |=> !O_IND0_SLOW;
    endproperty
    a_pin_zero_slew: assert property (p_pin_zero_slew) // see (RULE7)
        else $error("pin zero edge rate not fast for code zero");

    property p_reserved_reads_zero;
        @(posedge I_MCLK) disable iff (I_RST)
        (addr_phase && !I_HWRITE && I_HADDR[9:0] == EDGE_RATE_ADDR) |=> (O_HRDATA[7:4] == 4'h0);
    endproperty
    a_reserved_reads_zero: assert property (p_reserved_reads_zero) // see (RULE9)
        else $error("reserved slew bits read nonzero");

    property p_slew_write_loads;
        @(posedge I_MCLK) disable iff (I_RST)
        (wr_en && dp_addr_r == EDGE_RATE_ADDR) |=> (edge_r == $past(I_HWDATA[3:0]));
    endproperty
    a_slew_write_loads: assert property (p_slew_write_loads) // see (RULE6) see (RULE7)
        else $error("slew fields did not take the written value");
endmodule : ldsc_top

// ---- sim/tb_top.sv ----
// self-checking bench for the divider b and indicator edge-rate register block
module tb_top;
    import ldsc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic tick = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    wire logic [31:0] hrdata;
    wire logic hready;
    wire logic hresp;
    wire logic bclk;
    wire logic ind0;
    wire logic ind1;
    int err_count = 0;
    int n_checks = 0;

    // one slave on the bus, so its ready out is the bus ready
    ldsc_top dut (
        .I_MCLK(clk), .I_RST(rst), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
        .I_HWRITE(hwrite), .I_HSIZE(hsize), .I_HWDATA(hwdata), .I_HREADY(hready),
        .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp), .I_PREDIV_TICK(tick),
        .O_LVCMOS_B_CLK(bclk), .O_IND0_SLOW(ind0), .O_IND1_SLOW(ind1)
    );

    // 100 mhz system clock
    always #5 clk = ~clk;

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task complete_run;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run

    // single word transfer; waits on ready in both phases, no fixed latency assumed
    task automatic ahb_xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                            output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= wr;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        rd = hrdata;
        check("hresp", hresp, HRESP_OKAY);
    endtask : ahb_xfer

    task automatic ahb_write(input logic [31:0] a, input logic [31:0] wd);
        logic [31:0] dummy;
        ahb_xfer(1'b1, a, wd, dummy);
    endtask : ahb_write

    task automatic ahb_read(input logic [31:0] a, output logic [31:0] rd);
        ahb_xfer(1'b0, a, 32'h0, rd);
    endtask : ahb_read

    // one pre-divider pulse, then room for the output register to settle
    task automatic send_tick(output logic lvl);
        tick <= 1'b1;
        @(posedge clk);
        tick <= 1'b0;
        repeat (3) @(posedge clk);
        lvl = bclk;
    endtask : send_tick

    task automatic t_reset_values;
        logic [31:0] rd;
        check("bclk at reset", bclk, 32'h0);
        check("ind0 at reset", ind0, 32'h0);
        check("ind1 at reset", ind1, 32'h0);
        ahb_read(DIV_B_RATIO_ADDR, rd);
        check("divider reset", rd, {24'h0, DIV_B_RESET});
        ahb_read(EDGE_RATE_ADDR, rd);
        check("edge rate reset", rd, 32'h0);
        ahb_read(CHAN_STAT_ADDR, rd);
        check("stopped at reset", rd, 32'h0);
        // unmapped place swallows writes and reads zero
        ahb_write(32'h100, 32'hffffffff);
        ahb_read(32'h100, rd);
        check("unmapped", rd, 32'h0);
        ahb_read(CHAN_CTRL_ADDR, rd);
        check("control reads zero", rd, 32'h0);
    endtask : t_reset_values

    // every code on both fields at once; upper bits written as ones must read zero
    task automatic t_edge_rate;
        logic [31:0] rd;
        logic [1:0] f1;
        logic [1:0] f0;
        for (int c = 0; c < 4; c++) begin
            f1 = 2'(c);
            f0 = 2'(3 - c);
            ahb_write(EDGE_RATE_ADDR, {24'h0, 4'hf, f1, f0});
            ahb_read(EDGE_RATE_ADDR, rd);
            check("edge rate readback", rd, {28'h0, f1, f0});
            repeat (2) @(posedge clk);
            check("ind1 slow", ind1, {31'h0, f1 == EDGE_SLOW});
            check("ind0 slow", ind0, {31'h0, f0 == EDGE_SLOW});
        end
    endtask : t_edge_rate

    // load a code, stay parked until the soft reset, then measure duty and period
    task automatic t_divider(input logic [7:0] code);
        logic [31:0] rd;
        logic smp [0:511];
        int ratio;
        int highs;
        ratio = (code <= DIV_CODE_LOW_MAX) ? 6 : int'(code) + 1;
        ahb_write(DIV_B_RATIO_ADDR, {24'h0, code});
        ahb_read(DIV_B_RATIO_ADDR, rd);
        check("code readback", rd, {24'h0, code});
        ahb_read(CHAN_STAT_ADDR, rd);
        check("armed state", rd, {30'h0, DIV_ARMED});
        highs = 0;
        for (int i = 0; i < ratio; i++) begin
            send_tick(smp[i]);
            highs += (smp[i] !== 1'b0);
        end
        check("armed output held", highs, 32'h0);
        ahb_write(CHAN_CTRL_ADDR, 32'h1);
        // the pulse is registered once, so run shows one edge after the data phase
        @(posedge clk);
        ahb_read(CHAN_STAT_ADDR, rd);
        check("run state", rd, {29'h0, 1'b1, DIV_RUN});
        for (int i = 0; i < 2 * ratio; i++) send_tick(smp[i]);
        // any window of one period holds half the ratio high, rounded down for odd ratios, whatever the phase
        highs = 0;
        for (int i = 0; i < ratio; i++) highs += (smp[i] === 1'b1);
        check("high ticks per period", highs, ratio / 2);
        for (int i = 0; i < ratio; i++) begin
            check("period repeat", smp[i + ratio], smp[i]);
        end
        ahb_write(DIV_B_RATIO_ADDR, {24'h0, DIV_CODE_OFF});
        @(posedge clk);
        ahb_read(CHAN_STAT_ADDR, rd);
        check("stopped again", rd, 32'h0);
        check("stopped output", bclk, 32'h0);
    endtask : t_divider

    // main sequence: reset held four cycles, then the scenarios
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_reset_values();
        t_edge_rate();
        t_divider(8'h01);
        t_divider(8'h05);
        t_divider(8'h06);
        t_divider(8'h07);
        t_divider(8'hff);
        complete_run();
    end

    // watchdog well beyond the few thousand cycles the scenarios need
    initial begin
        #400000;
        err_count++;
        complete_run();
    end
endmodule : tb_top
